/* File: shared/mmp_defines.svh */
// Purpose: offsets, masks, reset values and field positions of the
//          memory map placement registers
// Assumes: 32-bit apb data, 12-bit byte address
// Notes:   definitions only
`ifndef MMP_DEFINES_SVH
`define MMP_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MMP_OFF_RAM      12'h000
`define MMP_OFF_IO       12'h004
`define MMP_OFF_NVM      12'h008
`define MMP_OFF_MISC     12'h00C

// ----------------------------------------------------------------------
// implemented bit masks
// ----------------------------------------------------------------------
`define MMP_MSK_RAM      8'hF9
`define MMP_MSK_IO       8'h78
`define MMP_MSK_NVM      8'hF9
`define MMP_MSK_MISC     8'h0F
`define MMP_MSK_NVM_POS  8'hF8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MMP_RST_RAM      8'h09
`define MMP_RST_IO       8'h00
`define MMP_RST_NVM      8'h00
`define MMP_RST_MISC     8'h0C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MMP_BASE_HI      7
`define MMP_BASE_LO      3
`define MMP_IO_HI        6
`define MMP_BIT_ALIGN    0
`define MMP_BIT_NVM_EN   0
`define MMP_BIT_FLASH_EN 0
`define MMP_BIT_HIGH     1
`define MMP_STR_HI       3
`define MMP_STR_LO       2

`endif

/* File: shared/mmp_pkg.sv */
// Purpose: types of the memory map placement block
// Assumes: mmp_defines.svh holds all numbers
// Notes:   state is one packed struct
package mmp_pkg;

  typedef enum logic [2:0] {
    MD_NORM_SINGLE,
    MD_NORM_EXP,
    MD_EMUL,
    MD_PERIPH,
    MD_SPEC_SINGLE,
    MD_SPEC_TEST
  } mmp_mode_t;

  typedef struct packed {
    logic [4:0] ram_base_bits;
    logic       ram_top_align;
    logic [4:0] io_block_base_bits;
    logic [4:0] nvm_base_bits;
    logic       nvm_window_enable;
    logic [1:0] external_wait_extend;
    logic       flash_high_half_only;
    logic       flash_map_enable;
  } mmp_map_t;

  typedef struct packed {
    logic [7:0]  ram;
    logic [7:0]  io;
    logic [7:0]  nvm;
    logic [7:0]  misc;
    logic        ram_once;
    logic        io_once;
    logic        nvm_once;
    logic        misc_once;
    logic        init;
    mmp_map_t    map;
    logic [31:0] rdata;
    logic        err;
  } mmp_state_t;

endpackage : mmp_pkg

/* File: src/mmp_regs.sv */
// Purpose: apb register bank placing ram, io block and nvm in the map
// Assumes: mode comes from core logic on pclk, no sync needed
// Notes:   map outputs follow register writes one cycle late
//
// Operation
// RULE1 - ram position written once unless special
// RULE2 - mapping changes one cycle after write
// RULE3 - ram bits 7:3 give address 15:11
// RULE4 - align bit picks bottom or top
// RULE5 - io position written once unless special
// RULE6 - io bit 7 zero, base below 0x8000
// RULE7 - io block on any 2K boundary
// RULE8 - nvm enable free, position per option
// RULE9 - nvm bits 7:3 give address 15:11
// RULE10 - nvm enable hides or shows nvm
// RULE11 - stretch code adds 0 to 3 clocks
// RULE12 - stretch ignored in single, peripheral modes
// RULE13 - high half bit blocks low flash
// RULE14 - flash enable removes or includes flash
// RULE15 - misc fields written once unless special
// RULE16 - misc reset values depend on mode
// RULE17 - io position resets to zero
// RULE18 - ram position resets to 0x09
// RULE19 - unimplemented bits read zero
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "mmp_defines.svh"

module mmp_regs #(
  parameter bit FLASH_EN_EXP_RST = 1'b1,
  parameter bit NVM_POS_ONCE     = 1'b0
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire mmp_pkg::mmp_mode_t mode,
  output mmp_pkg::mmp_map_t      map_o
);

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  mmp_pkg::mmp_state_t st_q;
  mmp_pkg::mmp_state_t st_d;

  logic       special;
  logic       single_like;
  logic       setup;
  logic       wr;
  logic       hit_ram;
  logic       hit_io;
  logic       hit_nvm;
  logic       hit_misc;
  logic       hit;
  logic       acc_ram;
  logic       acc_io;
  logic       acc_nvm_pos;
  logic       acc_nvm_en;
  logic       acc_misc;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;

  assign special     = (mode == mmp_pkg::MD_SPEC_SINGLE) ||
                       (mode == mmp_pkg::MD_SPEC_TEST);
  assign single_like = (mode == mmp_pkg::MD_NORM_SINGLE) ||
                       (mode == mmp_pkg::MD_SPEC_SINGLE) ||
                       (mode == mmp_pkg::MD_PERIPH);

  assign setup    = psel && !penable;
  assign wr       = psel && penable && pwrite;
  assign wbyte    = pwdata[7:0];
  assign hit_ram  = (paddr == `MMP_OFF_RAM);
  assign hit_io   = (paddr == `MMP_OFF_IO);
  assign hit_nvm  = (paddr == `MMP_OFF_NVM);
  assign hit_misc = (paddr == `MMP_OFF_MISC);
  assign hit      = hit_ram || hit_io || hit_nvm || hit_misc;

  // RULE1 once per normal boot
  assign acc_ram     = wr && hit_ram && (special || !st_q.ram_once);
  // RULE5 once per normal boot
  assign acc_io      = wr && hit_io && (special || !st_q.io_once);
  // RULE8 position lock optional
  assign acc_nvm_pos = wr && hit_nvm &&
                       (special || !NVM_POS_ONCE || !st_q.nvm_once);
  // RULE8 enable always writable
  assign acc_nvm_en  = wr && hit_nvm;
  // RULE15 misc fields locked together
  assign acc_misc    = wr && hit_misc && (special || !st_q.misc_once);

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  always_comb
  begin
    rd_byte = 8'h00;
    case (1'b1)
      hit_ram:  rd_byte = st_q.ram;
      hit_io:   rd_byte = st_q.io;
      hit_nvm:  rd_byte = st_q.nvm;
      hit_misc: rd_byte = st_q.misc;
      default:  rd_byte = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;

    // strap-like mode caught on the first edge after reset release
    if (!st_q.init)
    begin
      st_d.init = 1'b1;
      // RULE16 flash enable per mode
      case (mode)
        mmp_pkg::MD_SPEC_TEST:
          st_d.misc[`MMP_BIT_FLASH_EN] = 1'b0;
        mmp_pkg::MD_NORM_EXP,
        mmp_pkg::MD_EMUL:
          st_d.misc[`MMP_BIT_FLASH_EN] = FLASH_EN_EXP_RST;
        default:
          st_d.misc[`MMP_BIT_FLASH_EN] = 1'b1;
      endcase
    end

    // RULE19 only implemented bits stored
    if (acc_ram)
    begin
      st_d.ram = wbyte & `MMP_MSK_RAM;
    end
    if (wr && hit_ram && !special)
    begin
      st_d.ram_once = 1'b1;
    end

    // RULE6 bit 7 always zero
    if (acc_io)
    begin
      st_d.io = wbyte & `MMP_MSK_IO;
    end
    if (wr && hit_io && !special)
    begin
      st_d.io_once = 1'b1;
    end

    if (acc_nvm_pos)
    begin
      st_d.nvm = (st_q.nvm & ~`MMP_MSK_NVM_POS) |
                 (wbyte & `MMP_MSK_NVM_POS);
    end
    if (acc_nvm_en)
    begin
      st_d.nvm[`MMP_BIT_NVM_EN] = wbyte[`MMP_BIT_NVM_EN];
    end
    if (wr && hit_nvm && !special)
    begin
      st_d.nvm_once = 1'b1;
    end

    if (acc_misc)
    begin
      st_d.misc = wbyte & `MMP_MSK_MISC;
    end
    if (wr && hit_misc && !special)
    begin
      st_d.misc_once = 1'b1;
    end

    // RULE2 map follows stored value
    // RULE3 ram base bits
    st_d.map.ram_base_bits =
      st_q.ram[`MMP_BASE_HI:`MMP_BASE_LO];
    // RULE4 top or bottom align
    st_d.map.ram_top_align = st_q.ram[`MMP_BIT_ALIGN];
    // RULE7 2K granularity, low 32K only
    st_d.map.io_block_base_bits =
      {1'b0, st_q.io[`MMP_IO_HI:`MMP_BASE_LO]};
    // RULE9 nvm base bits
    st_d.map.nvm_base_bits =
      st_q.nvm[`MMP_BASE_HI:`MMP_BASE_LO];
    // RULE10 nvm shown only when enabled
    st_d.map.nvm_window_enable = st_q.nvm[`MMP_BIT_NVM_EN];
    // RULE11 stretch code passes on
    // RULE12 no stretch without external bus
    st_d.map.external_wait_extend = single_like ? 2'h0 :
      st_q.misc[`MMP_STR_HI:`MMP_STR_LO];
    // RULE13 low half blocking
    st_d.map.flash_high_half_only = st_q.misc[`MMP_BIT_HIGH];
    // RULE14 flash in or out of map
    st_d.map.flash_map_enable = st_q.misc[`MMP_BIT_FLASH_EN];

    // read data latched in setup, so it stands through access
    if (setup)
    begin
      st_d.rdata = {24'h000000, rd_byte};
      st_d.err   = !hit;
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // RULE18 ram reset value
      st_q.ram       <= `MMP_RST_RAM;
      // RULE17 io block at zero
      st_q.io        <= `MMP_RST_IO;
      st_q.nvm       <= `MMP_RST_NVM;
      // RULE16 stretch 3, high half off
      st_q.misc      <= `MMP_RST_MISC;
      st_q.ram_once  <= 1'b0;
      st_q.io_once   <= 1'b0;
      st_q.nvm_once  <= 1'b0;
      st_q.misc_once <= 1'b0;
      st_q.init      <= 1'b0;
      st_q.map       <= '0;
      st_q.rdata     <= 32'h00000000;
      st_q.err       <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // zero wait states keeps the core bus timing simple
  assign pready  = 1'b1;
  assign prdata  = st_q.rdata;
  assign pslverr = psel && penable && st_q.err;
  assign map_o   = st_q.map;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ram_wr;
    acc_ram ##1 1'b1;
  endsequence

  sequence s_nvm_off;
    acc_nvm_en && !wbyte[`MMP_BIT_NVM_EN] ##1 !acc_nvm_en;
  endsequence

  a_ram_once_lock: assert property ( // RULE1
    (wr && hit_ram && st_q.ram_once && !special && st_q.init)
      |=> (st_q.ram == $past(st_q.ram)))
    else $error("ram position changed after lock");

  a_ram_map_late: assert property ( // RULE2
    acc_ram |=> (map_o.ram_base_bits == $past(map_o.ram_base_bits)))
    else $error("ram map changed in write cycle");

  a_ram_base_map: assert property ( // RULE3
    s_ram_wr |=> (map_o.ram_base_bits ==
                  $past(wbyte[`MMP_BASE_HI:`MMP_BASE_LO], 2)))
    else $error("ram base not applied after one cycle");

  a_ram_align: assert property ( // RULE4
    acc_ram |-> ##2 (map_o.ram_top_align ==
                     $past(wbyte[`MMP_BIT_ALIGN], 2)))
    else $error("ram align bit not applied");

  a_io_once_lock: assert property ( // RULE5
    (wr && hit_io && st_q.io_once && !special)
      |=> $stable(st_q.io))
    else $error("io position changed after lock");

  a_io_low_half: assert property ( // RULE6
    !map_o.io_block_base_bits[4] && !st_q.io[`MMP_BASE_HI])
    else $error("io base above 0x7FFF");

  a_nvm_off_map: assert property ( // RULE10
    s_nvm_off |=> !map_o.nvm_window_enable)
    else $error("nvm still mapped after disable");

  a_stretch_single: assert property ( // RULE12
    $past(single_like) |-> (map_o.external_wait_extend == 2'h0))
    else $error("stretch applied without external bus");

  a_misc_once_lock: assert property ( // RULE15
    (wr && hit_misc && st_q.misc_once && !special)
      |=> $stable(st_q.misc))
    else $error("misc changed after lock");

  a_misc_reset: assert property ( // RULE16
    $rose(st_q.init) |->
      (st_q.misc[`MMP_STR_HI:`MMP_STR_LO] == 2'h3) &&
      !st_q.misc[`MMP_BIT_HIGH] &&
      (st_q.misc[`MMP_BIT_FLASH_EN] ==
        (($past(mode) == mmp_pkg::MD_SPEC_TEST) ? 1'b0 :
         (($past(mode) == mmp_pkg::MD_NORM_EXP) ||
          ($past(mode) == mmp_pkg::MD_EMUL)) ? FLASH_EN_EXP_RST : 1'b1)))
    else $error("misc reset value wrong");

  a_unused_zero: assert property ( // RULE19
    (prdata[31:8] == 24'h000000) &&
    ((st_q.misc & ~`MMP_MSK_MISC) == 8'h00) &&
    ((st_q.ram & ~`MMP_MSK_RAM) == 8'h00))
    else $error("unimplemented bits not zero");

  a_unmapped_err: assert property (
    (setup && !hit) ##1 (psel && penable) |-> pslverr)
    else $error("unmapped access without error");

  a_io_base_map: assert property ( // RULE7
    acc_io |-> ##2 (map_o.io_block_base_bits ==
                    {1'b0, $past(wbyte[`MMP_IO_HI:`MMP_BASE_LO], 2)}))
    else $error("io base not applied");

  a_nvm_en_free: assert property ( // RULE8
    (wr && hit_nvm) |=> (st_q.nvm[`MMP_BIT_NVM_EN] ==
                         $past(wbyte[`MMP_BIT_NVM_EN])))
    else $error("nvm enable write refused");

  a_nvm_base_map: assert property ( // RULE9
    acc_nvm_pos |-> ##2 (map_o.nvm_base_bits ==
                         $past(wbyte[`MMP_BASE_HI:`MMP_BASE_LO], 2)))
    else $error("nvm base not applied");

  a_nvm_map_late: assert property ( // RULE2
    acc_nvm_en |=> $stable(map_o.nvm_window_enable))
    else $error("nvm map changed in write cycle");

  a_misc_map_late: assert property ( // RULE2
    acc_misc |=> $stable(map_o.flash_high_half_only))
    else $error("misc map changed in write cycle");

  // init guard: map holds reset values only from the second edge
  a_stretch_pass: assert property ( // RULE11
    (st_q.init && !$past(single_like)) |->
      (map_o.external_wait_extend ==
       $past(st_q.misc[`MMP_STR_HI:`MMP_STR_LO])))
    else $error("stretch code not passed on");

  a_high_half_map: assert property ( // RULE13
    st_q.init |-> (map_o.flash_high_half_only ==
                   $past(st_q.misc[`MMP_BIT_HIGH])))
    else $error("high half bit not applied");

  a_flash_map: assert property ( // RULE14
    st_q.init |-> (map_o.flash_map_enable ==
                   $past(st_q.misc[`MMP_BIT_FLASH_EN])))
    else $error("flash enable not applied");

  a_ram_special: assert property ( // RULE1
    (wr && hit_ram && special) |=>
      (st_q.ram == ($past(wbyte) & `MMP_MSK_RAM)))
    else $error("ram write refused in special mode");

  a_io_special: assert property ( // RULE5
    (wr && hit_io && special) |=>
      (st_q.io == ($past(wbyte) & `MMP_MSK_IO)))
    else $error("io write refused in special mode");

  a_misc_special: assert property ( // RULE15
    (wr && hit_misc && special) |=>
      (st_q.misc == ($past(wbyte) & `MMP_MSK_MISC)))
    else $error("misc write refused in special mode");

  a_io_reset: assert property ( // RULE17
    $rose(st_q.init) |-> (st_q.io == `MMP_RST_IO))
    else $error("io position reset value wrong");

  a_ram_reset: assert property ( // RULE18
    $rose(st_q.init) |-> (st_q.ram == `MMP_RST_RAM))
    else $error("ram position reset value wrong");

endmodule : mmp_regs

/* File: verification/mmp_cpu_model.sv */
// Purpose: core side bus master of the map registers
// Assumes: slave may stretch the access phase
// Notes:   released address and data show inverted values
`timescale 1ns/100ps

module mmp_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'hFFF;
    pwdata  = 32'hFFFFFFFF;
  end

  // ---------------------------------
  // one transfer
  // ---------------------------------
  // request held until pready, so no wait count is assumed
  task automatic xfer(
    input  logic        w,
    input  logic [11:0] a,
    input  logic [31:0] d,
    output logic [32:0] r
  );
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= ~w;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : mmp_cpu_model

/* File: verification/mmp_regs_tb.sv */
// Purpose: self-checking bench of the map placement registers
// Assumes: default parameters of the register bank
// Notes:   mode driven directly by the bench
`timescale 1ns/100ps
`include "mmp_defines.svh"

module mmp_regs_tb;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic [32:0]        r;
  mmp_pkg::mmp_mode_t mode = mmp_pkg::MD_NORM_SINGLE;
  mmp_pkg::mmp_map_t  map, em;
  int                 bad_count = 0;
  int                 comparisons = 0;

  always #10 pclk = ~pclk;

  mmp_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
    .map_o(map));

  mmp_cpu_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ---------------------------------
  // helpers
  // ---------------------------------
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, {24'h0, d}, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    u_cpu.xfer(1'b0, a, 32'h0, r);
    chk(r, {25'h0, e});
  endtask : rd

  // off-edge look, after the edge's updates land
  task automatic chkm;
    #1;
    chk({12'h0, map}, {12'h0, em});
  endtask : chkm

  task automatic do_reset(input mmp_pkg::mmp_mode_t m);
    mode    <= m;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  task automatic stop_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_reset;
    rd(`MMP_OFF_RAM, 8'h09);
    rd(`MMP_OFF_IO, 8'h00);
    rd(`MMP_OFF_NVM, 8'h00);
    rd(`MMP_OFF_MISC, 8'h0D);
    em = '{5'h01, 1'b1, 5'h00, 5'h00, 1'b0, 2'h0, 1'b0, 1'b1};
    chkm;
  endtask : t_reset

  task automatic t_once;
    @(posedge pclk);
    mode <= mmp_pkg::MD_NORM_EXP;
    wr(`MMP_OFF_RAM, 8'hFF);
    wr(`MMP_OFF_IO, 8'hFF);
    wr(`MMP_OFF_MISC, 8'hF2);
    wr(`MMP_OFF_RAM, 8'h00);
    wr(`MMP_OFF_IO, 8'h00);
    wr(`MMP_OFF_MISC, 8'hFF);
    rd(`MMP_OFF_RAM, 8'hF9);
    rd(`MMP_OFF_IO, 8'h78);
    rd(`MMP_OFF_MISC, 8'h02);
    em = '{5'h1F, 1'b1, 5'h0F, 5'h00, 1'b0, 2'h0, 1'b1, 1'b0};
    chkm;
  endtask : t_once

  task automatic t_delay;
    wr(`MMP_OFF_NVM, 8'hA9);
    chkm;
    @(posedge pclk);
    em.nvm_base_bits     = 5'h15;
    em.nvm_window_enable = 1'b1;
    chkm;
    wr(`MMP_OFF_NVM, 8'h50);
    rd(`MMP_OFF_NVM, 8'h50);
    em.nvm_base_bits     = 5'h0A;
    em.nvm_window_enable = 1'b0;
    chkm;
  endtask : t_delay

  task automatic t_spec;
    do_reset(mmp_pkg::MD_SPEC_TEST);
    rd(`MMP_OFF_MISC, 8'h0C);
    wr(`MMP_OFF_RAM, 8'hF8);
    wr(`MMP_OFF_RAM, 8'h08);
    wr(`MMP_OFF_IO, 8'h48);
    wr(`MMP_OFF_IO, 8'h30);
    rd(`MMP_OFF_RAM, 8'h08);
    rd(`MMP_OFF_IO, 8'h30);
    em = '{5'h01, 1'b0, 5'h06, 5'h00, 1'b0, 2'h3, 1'b0, 1'b1};
    for (int k = 0; k < 4; k++)
    begin
      wr(`MMP_OFF_MISC, 8'(k * 4 + 1));
      @(posedge pclk);
      em.external_wait_extend = 2'(k);
      chkm;
    end
    @(posedge pclk);
    mode <= mmp_pkg::MD_PERIPH;
    repeat (2) @(posedge pclk);
    em.external_wait_extend = 2'h0;
    chkm;
  endtask : t_spec

  // emulation locks like normal; special single has no stretch
  task automatic t_modes;
    do_reset(mmp_pkg::MD_EMUL);
    rd(`MMP_OFF_MISC, 8'h0D);
    wr(`MMP_OFF_MISC, 8'h06);
    wr(`MMP_OFF_MISC, 8'h0D);
    wr(`MMP_OFF_RAM, 8'h41);
    wr(`MMP_OFF_RAM, 8'h09);
    rd(`MMP_OFF_RAM, 8'h41);
    rd(`MMP_OFF_MISC, 8'h06);
    em = '{5'h08, 1'b1, 5'h00, 5'h00, 1'b0, 2'h1, 1'b1, 1'b0};
    chkm;
    do_reset(mmp_pkg::MD_SPEC_SINGLE);
    rd(`MMP_OFF_MISC, 8'h0D);
    wr(`MMP_OFF_MISC, 8'h0E);
    wr(`MMP_OFF_MISC, 8'h0B);
    rd(`MMP_OFF_MISC, 8'h0B);
    em = '{5'h01, 1'b1, 5'h00, 5'h00, 1'b0, 2'h0, 1'b1, 1'b1};
    chkm;
  endtask : t_modes

  // unmapped place: error flag, no data, no effect
  task automatic t_unmapped;
    u_cpu.xfer(1'b1, 12'h010, 32'hFF, r);
    chk({32'h0, r[32]}, 33'h1);
    u_cpu.xfer(1'b0, 12'h010, 32'h0, r);
    chk(r, {1'b1, 32'h0});
  endtask : t_unmapped

  initial
  begin
    do_reset(mmp_pkg::MD_NORM_SINGLE);
    t_reset();
    t_once();
    t_delay();
    t_spec();
    t_modes();
    t_unmapped();
    stop_test();
  end

  // hang guard, far beyond the roughly 170 cycles needed
  initial
  begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    stop_test();
  end
endmodule : mmp_regs_tb
